// [core/sgc_gate_ctrl.sv]
`timescale 1ns/1ns
// Contract
// [RULE_01] start on chosen edge, lead or pod
// [RULE_02] stop on chosen edge, lead or pod
// [RULE_03] clock on rising, falling or both edges
// [RULE_04] clock source lead or pod, independent
// [RULE_05] external enable active at chosen level
// [RULE_06] always-enabled option ignores enable lead
// [RULE_07] stop counter ends gate at limit
// [RULE_08] power-up: rising edges, external leads
// [RULE_09] power-up: enable always true
// [RULE_10] selections volatile, reset restores defaults
// [RULE_11] selections hold last written value
// [RULE_12] gate spans start to stop event
// [RULE_13] stop counter disableable, limit 1..4095
// [RULE_14] gated clock needs gate and enable
// [RULE_15] stops outside gate are ignored
module sgc_gate_ctrl
	import sgc_pkg::*;
#(
	parameter int CNT_W = COUNT_W
)(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic [3:0]       addr_i,
	input  wire logic [15:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [15:0]      rdata_o,
	input  wire logic             external_start_lead_i,
	input  wire logic             external_stop_lead_i,
	input  wire logic             external_clock_lead_i,
	input  wire logic             external_enable_lead_i,
	input  wire logic             pod_sync_i,
	output logic                  gate_o,
	output logic                  gated_clk_o,
	output logic                  gate_done_o
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (CNT_W < 1 || CNT_W > 16)
	begin : g_chk
		$error("CNT_W must be 1..16");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [1:0]       start_cfg;
		logic [1:0]       stop_cfg;
		logic [2:0]       clock_cfg;
		logic [1:0]       ena_cfg;
		logic             scnt_en;
		logic [SCNT_W-1:0] scnt_lim;
		logic             free_run;
		logic [4:0]       sy1;
		logic [4:0]       sy2;
		logic [4:0]       prev;
		sgc_gate_e        gs;
		logic [SCNT_W-1:0] scnt;
		logic [CNT_W-1:0] count;
		logic             gate;
		logic             gclk;
		logic             done;
		logic [15:0]      rdata;
	} sgc_state_s;

	sgc_state_s st_r;
	sgc_state_s st_nxt;

	// edge of a sampled line; both-edge for clock handled by caller
	function automatic logic edge_hit(input logic cur, input logic old,
		input logic falling);
		edge_hit = falling ? (old & ~cur) : (~old & cur);
	endfunction : edge_hit

	// pod sync overrides the event's own lead when selected
	function automatic logic pick_line(input logic pod_sel,
		input logic [4:0] lines, input logic [2:0] lead_idx);
		pick_line = pod_sel ? lines[4] : lines[lead_idx];
	endfunction : pick_line

	logic [4:0] raw;
	logic start_ln, stop_ln, clk_ln, start_ev, stop_ev, clk_ev, ena_ok;
	logic clk_rise, clk_fall, lim_hit;

	assign raw = {pod_sync_i, external_enable_lead_i,
		external_clock_lead_i, external_stop_lead_i,
		external_start_lead_i};

	always_comb
	begin
		st_nxt = st_r;
		// two-flop synchroniser, then a history flop for edges
		st_nxt.sy1  = raw;
		st_nxt.sy2  = st_r.sy1;
		st_nxt.prev = st_r.sy2;
		st_nxt.gclk = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.rdata = 16'h0000;

		// ************************************************************
		// event selection
		// ************************************************************
		start_ln = pick_line(st_r.start_cfg[SRC_BIT], st_r.sy2, 3'h0);
		start_ev = edge_hit(start_ln,
			pick_line(st_r.start_cfg[SRC_BIT], st_r.prev, 3'h0),
			st_r.start_cfg[EDGE_BIT]); // [RULE_01]
		stop_ln = pick_line(st_r.stop_cfg[SRC_BIT], st_r.sy2, 3'h1);
		stop_ev = edge_hit(stop_ln,
			pick_line(st_r.stop_cfg[SRC_BIT], st_r.prev, 3'h1),
			st_r.stop_cfg[EDGE_BIT]); // [RULE_02]
		clk_ln = pick_line(st_r.clock_cfg[CKSRC_BIT], st_r.sy2,
			3'h2); // [RULE_04]
		clk_rise = edge_hit(clk_ln,
			pick_line(st_r.clock_cfg[CKSRC_BIT], st_r.prev, 3'h2), 1'b0);
		clk_fall = edge_hit(clk_ln,
			pick_line(st_r.clock_cfg[CKSRC_BIT], st_r.prev, 3'h2), 1'b1);
		case (st_r.clock_cfg[1:0]) // [RULE_03]
			CK_RISE: clk_ev = clk_rise;
			CK_FALL: clk_ev = clk_fall;
			CK_BOTH: clk_ev = clk_rise | clk_fall;
			default: clk_ev = clk_rise;
		endcase
		if (!st_r.ena_cfg[ENA_EXT_BIT])
			ena_ok = 1'b1; // [RULE_06]
		else
			ena_ok = st_r.sy2[3] ^ st_r.ena_cfg[ENA_LOW_BIT]; // [RULE_05]
		lim_hit = 1'b0;

		// ************************************************************
		// gate sequencer
		// ************************************************************
		case (st_r.gs)
			GS_IDLE:
			begin
				st_nxt.gate = st_r.free_run;
			end
			GS_ARMED:
			begin
				// stops before a start are dropped
				if (start_ev) // [RULE_15]
				begin
					st_nxt.gs    = GS_OPEN; // [RULE_12]
					st_nxt.gate  = 1'b1;
					st_nxt.scnt  = '0;
					st_nxt.count = '0;
				end
			end
			GS_OPEN:
			begin
				if (clk_ev && ena_ok) // [RULE_14]
				begin
					st_nxt.gclk  = 1'b1;
					st_nxt.count = st_r.count + 1'b1;
					st_nxt.scnt  = st_r.scnt + 1'b1;
					lim_hit = st_r.scnt_en && (st_r.scnt_lim != '0) &&
						(st_r.scnt + 1'b1 == st_r.scnt_lim); // [RULE_07] [RULE_13]
				end
				if (stop_ev || lim_hit) // [RULE_12]
				begin
					st_nxt.gs   = GS_IDLE;
					st_nxt.gate = st_r.free_run;
					st_nxt.done = 1'b1;
				end
			end
			default: st_nxt.gs = GS_IDLE;
		endcase
		// free-running mode counts every enabled clock while the sequencer is idle, not while armed
		if (st_r.free_run && st_r.gs == GS_IDLE && clk_ev && ena_ok)
		begin
			st_nxt.gclk  = 1'b1;
			st_nxt.count = st_r.count + 1'b1;
		end

		// ************************************************************
		// register port
		// ************************************************************
		if (wr_i) // [RULE_11]
		begin
			case (addr_i)
				ADDR_START_CFG: st_nxt.start_cfg = wdata_i[1:0];
				ADDR_STOP_CFG:  st_nxt.stop_cfg  = wdata_i[1:0];
				ADDR_CLOCK_CFG:
					if (wdata_i[1:0] != 2'h3)
						st_nxt.clock_cfg = wdata_i[2:0];
				ADDR_ENA_CFG:   st_nxt.ena_cfg   = wdata_i[1:0];
				ADDR_STOP_CNT:
				begin
					st_nxt.scnt_lim = wdata_i[SCNT_W-1:0];
					st_nxt.scnt_en  = wdata_i[SCNT_EN_BIT];
				end
				ADDR_CONTROL:
				begin
					st_nxt.free_run = wdata_i[CTL_FREE_BIT];
					if (wdata_i[CTL_ARM_BIT])
					begin
						st_nxt.gs   = GS_ARMED;
						st_nxt.gate = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (rd_i)
		begin
			case (addr_i)
				ADDR_START_CFG: st_nxt.rdata = {14'h0000, st_r.start_cfg};
				ADDR_STOP_CFG:  st_nxt.rdata = {14'h0000, st_r.stop_cfg};
				ADDR_CLOCK_CFG: st_nxt.rdata = {13'h0000, st_r.clock_cfg};
				ADDR_ENA_CFG:   st_nxt.rdata = {14'h0000, st_r.ena_cfg};
				ADDR_STOP_CNT:
					st_nxt.rdata = {3'h0, st_r.scnt_en, st_r.scnt_lim};
				ADDR_CONTROL:   st_nxt.rdata = {14'h0000, st_r.free_run, 1'b0};
				ADDR_STATUS:
					st_nxt.rdata = {12'h000, st_r.sy2[3], st_r.gate,
						st_r.gs == GS_OPEN, st_r.gs == GS_ARMED};
				ADDR_COUNT:
					st_nxt.rdata = 16'(st_r.count);
				default: st_nxt.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// power-up defaults, only the synchroniser flops survive a reset
			st_r           <= '0; // [RULE_10]
			// synchroniser keeps tracking the pins: a lead idling high
			// must not look like a fresh edge once reset lifts
			st_r.sy1       <= st_nxt.sy1;
			st_r.sy2       <= st_nxt.sy2;
			st_r.prev      <= st_nxt.prev;
			st_r.start_cfg <= {SRC_EXT, EDGE_RISE}; // [RULE_08]
			st_r.stop_cfg  <= {SRC_EXT, EDGE_RISE}; // [RULE_08]
			st_r.clock_cfg <= {SRC_EXT, CK_RISE}; // [RULE_08]
			st_r.ena_cfg   <= ENA_ALWAYS; // [RULE_09]
			st_r.scnt_lim  <= SCNT_RST;
			st_r.gs        <= GS_IDLE;
		end
		else if (ce_i)
			st_r <= st_nxt;
	end

	assign rdata_o     = st_r.rdata;
	assign gate_o      = st_r.gate;
	assign gated_clk_o = st_r.gclk;
	assign gate_done_o = st_r.done;
endmodule : sgc_gate_ctrl

// [core/sgc_pkg.sv]
package sgc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [3:0] ADDR_START_CFG = 4'h0;
	localparam logic [3:0] ADDR_STOP_CFG  = 4'h1;
	localparam logic [3:0] ADDR_CLOCK_CFG = 4'h2;
	localparam logic [3:0] ADDR_ENA_CFG   = 4'h3;
	localparam logic [3:0] ADDR_STOP_CNT  = 4'h4;
	localparam logic [3:0] ADDR_CONTROL   = 4'h5;
	localparam logic [3:0] ADDR_STATUS    = 4'h6;
	localparam logic [3:0] ADDR_COUNT     = 4'h7;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int EDGE_BIT    = 0;
	localparam int SRC_BIT     = 1;
	localparam int CKMODE_LSB  = 0;
	localparam int CKSRC_BIT   = 2;
	localparam int ENA_EXT_BIT = 0;
	localparam int ENA_LOW_BIT = 1;
	localparam int SCNT_EN_BIT = 12;
	localparam int CTL_ARM_BIT = 0;
	localparam int CTL_FREE_BIT = 1;

	// ************************************************************
	// encodings and reset values
	// ************************************************************
	localparam logic       EDGE_RISE   = 1'b0;
	localparam logic       SRC_EXT     = 1'b0;
	localparam logic [1:0] CK_RISE     = 2'h0;
	localparam logic [1:0] CK_FALL     = 2'h1;
	localparam logic [1:0] CK_BOTH     = 2'h2;
	localparam logic [1:0] ENA_ALWAYS  = 2'h0;
	localparam logic [11:0] SCNT_RST   = 12'h000;
	localparam int          SCNT_W     = 12;
	localparam int          COUNT_W    = 16;

	typedef enum logic [1:0] {
		GS_IDLE,
		GS_ARMED,
		GS_OPEN
	} sgc_gate_e;
endpackage : sgc_pkg

// [test/sgc_gate_ctrl_props.sv]
`timescale 1ns/1ns
module sgc_gate_ctrl_props
	import sgc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rdata_o,
	input  wire logic        gate_o,
	input  wire logic        gated_clk_o,
	input  wire logic        gate_done_o
);
	// ********
	// checks
	// ********
	logic ctl_r;
	// a gate may only open once control has been written
	always_ff @(posedge clk_i)
		ctl_r <= rst_i ? 1'b0 : ctl_r | (wr_i && addr_i == ADDR_CONTROL);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
		else $error("read data outside slot");
	a_unmapped_zero: assert property (rd_i && addr_i[3] |=> rdata_o == 16'h0)
		else $error("unmapped read not zero");
	a_done_pulse: assert property (gate_done_o |=> !gate_done_o)
		else $error("done longer than a cycle");
	a_clk_in_gate: assert property (gated_clk_o |-> gate_o || $past(gate_o))
		else $error("clock counted outside gate");
	a_done_after_gate: assert property (gate_done_o |-> $past(gate_o))
		else $error("done without open gate");
	a_reset_quiet: assert property ($past(rst_i) |->
		!gate_o && !gated_clk_o && !gate_done_o && rdata_o == 16'h0)
		else $error("outputs active after reset");
	a_gate_needs_arm: assert property ($rose(gate_o) |-> ctl_r)
		else $error("gate opened unarmed");
	a_start_readback: assert property (
		(wr_i && addr_i == ADDR_START_CFG) ##2
		(rd_i && addr_i == ADDR_START_CFG)
		|=> rdata_o == ($past(wdata_i, 3) & 16'h0003))
		else $error("start setting not kept");
	c_clk: cover property (gated_clk_o);
	c_done: cover property (gate_done_o);
	c_open: cover property ($rose(gate_o));
endmodule : sgc_gate_ctrl_props

bind sgc_gate_ctrl sgc_gate_ctrl_props u_props (.clk_i(clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .gate_o(gate_o),
	.gated_clk_o(gated_clk_o), .gate_done_o(gate_done_o));

// [test/sgc_uut_model.sv]
`timescale 1ns/1ns
module sgc_uut_model (
	input  wire logic pod_i,
	output logic      clk_lead_o,
	output logic      pod_sync_o
);
	logic lvl = 1'b0;
	// unselected line idles low, no edges between frames
	assign clk_lead_o = pod_i ? 1'b0 : lvl;
	assign pod_sync_o = pod_i ? lvl : 1'b0;
	// phase locked to the bench clock, each edge 3 ns before a rising edge
	task automatic burst(input int n);
		#37;
		repeat (n)
		begin
			#80 lvl = 1'b1;
			#80 lvl = 1'b0;
		end
	endtask : burst
endmodule : sgc_uut_model

// [test/sgc_gate_ctrl_tb_top.sv]
`timescale 1ns/1ns
module sgc_gate_ctrl_tb_top
	import sgc_pkg::*;
;
	logic        clk_i, rst_i, wr_i, rd_i, st, sp, en, pod, lc, sy;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o, got, ck, ena;
	logic        gate_o, gated_clk_o, gate_done_o;
	int          mismatches, n_compared, pulses, seed, k, lim, ex;

	sgc_gate_ctrl u_sgc_gate_ctrl (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .external_start_lead_i(st),
		.external_stop_lead_i(sp), .external_clock_lead_i(lc),
		.external_enable_lead_i(en), .pod_sync_i(sy), .gate_o(gate_o),
		.gated_clk_o(gated_clk_o), .gate_done_o(gate_done_o));
	sgc_uut_model u_sgc_uut_model (.pod_i(pod), .clk_lead_o(lc),
		.pod_sync_o(sy));

	task automatic chk(input string nm, input logic [15:0] e, a);
		n_compared++;
		if (e !== a)
		begin
			mismatches++;
			$display("wrong value %s exp %h got %h", nm, e, a);
		end
	endtask : chk
	// one idle cycle after each strobe keeps drivers race free
	task automatic bus(input logic w, input logic [3:0] a, input int d);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= 16'(d);
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1 got = rdata_o;
		@(posedge clk_i);
	endtask : bus
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	// every register at its default, status as given
	task automatic dflt(input logic [15:0] stat);
		for (int i = 0; i < 9; i++)
		begin
			bus(0, 4'(i), 0);
			chk("reg", i == 6 ? stat : 16'h0, got);
		end
	endtask : dflt
	task automatic summarize();
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(negedge clk_i)
		if (gated_clk_o === 1'b1)
			pulses++;
	initial
	begin
		#100000 mismatches++;
		summarize();
	end
	initial
	begin
		{rst_i, wr_i, rd_i, st, sp, en, pod} = 7'h40;
		{addr_i, wdata_i} = 20'h0;
		seed = 32'h84c29c29;
		wt(2);
		rst_i <= 1'b0;
		dflt(16'h0);
		bus(1, ADDR_START_CFG, 3);
		bus(0, ADDR_START_CFG, 0);
		chk("start", 16'h3, got);
		// mode 3 is no clock choice and must leave the setting alone
		bus(1, ADDR_CLOCK_CFG, 3);
		bus(0, ADDR_CLOCK_CFG, 0);
		chk("refused", 16'h0, got);
		for (int j = 0; j < 7; j++)
		begin
			k = 3 + j;
			lim = 1 + {$random(seed)} % (k - 1);
			ck = j < 3 ? 16'(j) : (j == 5 ? 16'h4 : 16'h0);
			ena = j == 3 ? 16'h3 : (j == 4 ? 16'h1 : 16'h0);
			ex = j == 4 ? 0 : (j == 2 ? 2 * k : (j == 6 ? lim : k));
			st <= j[0];
			sp <= j[0];
			pod <= j == 5;
			en <= j > 2 && j < 5 ? 1'b0 : 1'($random(seed));
			bus(1, ADDR_START_CFG, j[0]);
			bus(1, ADDR_STOP_CFG, j[0]);
			bus(1, ADDR_CLOCK_CFG, ck);
			bus(1, ADDR_ENA_CFG, ena);
			bus(1, ADDR_STOP_CNT, j == 6 ? 16'h1000 | lim : 0);
			sp <= !j[0];
			wt(6);
			chk("early", 16'h0, 16'(gate_o));
			sp <= j[0];
			bus(1, ADDR_CONTROL, 1);
			st <= !j[0];
			wt(6);
			chk("gate", 16'h1, 16'(gate_o));
			pulses = 0;
			u_sgc_uut_model.burst(k);
			wt(6);
			sp <= !j[0];
			wt(6);
			chk("close", 16'h0, 16'(gate_o));
			bus(0, ADDR_COUNT, 0);
			chk("count", 16'(ex), got);
			chk("pulses", 16'(ex), 16'(pulses));
		end
		// free run: count carries on from the last gate, gate held high
		bus(1, ADDR_CONTROL, 2);
		wt(2);
		chk("free gate", 16'h1, 16'(gate_o));
		pulses = 0;
		u_sgc_uut_model.burst(5);
		wt(6);
		bus(0, ADDR_COUNT, 0);
		chk("free count", 16'(lim + 5), got);
		chk("free pulses", 16'h5, 16'(pulses));
		// mid-run reset with start lead high, armed at once
		en <= 1'b0;
		rst_i <= 1'b1;
		wt(2);
		rst_i <= 1'b0;
		bus(1, ADDR_CONTROL, 1);
		wt(6);
		chk("false start", 16'h0, 16'(gate_o));
		dflt(16'h1);
		summarize();
	end
endmodule : sgc_gate_ctrl_tb_top
